// *** rtl/rmcs_defs.svh ***
// offsets, codes, reset values and timing figures of the modem transmit sequencer
`ifndef RMCS_DEFS_SVH
`define RMCS_DEFS_SVH

// serial command and prompt characters
`define RMCS_CMD_TX_BYTE 8'h24
`define RMCS_PROMPT_BYTE 8'h3A

// system clock rate
`define RMCS_CLK_MHZ 250

// times in microseconds, as printed; the timeout unit in nanoseconds, the ack burst in milliseconds
`define RMCS_DELAY_UNIT_US 1000
`define RMCS_SETTLE_BIT_US 620
`define RMCS_TAIL_UNIT_US 1000
`define RMCS_TIMEOUT_UNIT_NS 410000
`define RMCS_ACK_UNIT_US 1000
`define RMCS_ACK_BURST_MS 8'h14

// power-on values of the timing settings
`define RMCS_DEF_DELAY 8'h05
`define RMCS_DEF_SETTLE 8'h11
`define RMCS_DEF_TAIL 8'h05
`define RMCS_DEF_TIMEOUT 8'h30
`define RMCS_DEF_TRIES 8'h03

// setting select codes, also the nonvolatile address
`define RMCS_SEL_DELAY 3'h0
`define RMCS_SEL_SETTLE 3'h1
`define RMCS_SEL_TAIL 3'h2
`define RMCS_SEL_TIMEOUT 3'h3
`define RMCS_SEL_TRIES 3'h4

`endif

// *** rtl/rmcs_pkg.sv ***
// types of the modem transmit sequencer
package rmcs_pkg;
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_CMD_LEN,
    ST_CMD_PROMPT,
    ST_CMD_DATA,
    ST_DELAY,
    ST_PREAMBLE,
    ST_SEND,
    ST_ACK_WAIT,
    ST_HOLD,
    ST_ACK_BURST
  } rmcs_state_type;
endpackage : rmcs_pkg

// *** rtl/rmcs_fifo.sv ***
// byte fifo with registered full and empty, plus mark and rewind for resends
`timescale 1ns/1ns
module rmcs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i,
  input wire logic mark_i,
  input wire logic rewind_i
);
  // depth must be a power of two; pointers carry one wrap bit
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] mark_ptr;
  logic full;
  logic empty;
  wire logic do_push = ce_i && in_valid_i && !full;
  wire logic do_pop = ce_i && out_ready_i && !empty && !rewind_i;
  wire logic [AW:0] next_wr = do_push ? wr_ptr + 1'b1 : wr_ptr;
  wire logic [AW:0] next_rd = (ce_i && rewind_i) ? mark_ptr : (do_pop ? rd_ptr + 1'b1 : rd_ptr);
  wire logic [AW:0] next_fill = next_wr - next_rd;

  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem[rd_ptr[AW-1:0]];

  // flags are registered so the host ready comes straight from a flop
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      mark_ptr <= '0;
      full <= 1'b0;
      empty <= 1'b1;
    end else if (ce_i) begin
      wr_ptr <= next_wr;
      rd_ptr <= next_rd;
      if (mark_i) mark_ptr <= rd_ptr;
      full <= (next_fill == (AW+1)'(DEPTH));
      empty <= (next_fill == '0);
    end
  end

  // storage needs no reset
  always_ff @(posedge clock_i) begin
    if (do_push) mem[wr_ptr[AW-1:0]] <= in_data_i;
  end
endmodule : rmcs_fifo

// *** rtl/rmcs_top.sv ***
// command-mode transmit and radio timing sequencer of the half-duplex modem
//
// Summary of operation
// R1: a command transmit is the dollar byte then one hex length character
// R2: payload is length code plus one bytes, 1 to 16, all collected
// R3: a colon prompt goes back to the host right after the length
// R4: after the last data byte the radio keys up and sends the packet
// R5: a command transmit ends back in setup mode, never transparent
// R6: start delay runs from first byte into an empty buffer
// R7: defaults give 5 ms start delay and about 10 ms preamble
// R8: after key-up the preamble runs before any packet data
// R9: the packet is closed before preamble; later bytes wait
// R10: transmitter stays on for hold-off; no new send until it ends
// R11: streaming at 4800 baud loses nothing; back-pressure holds the host
// R12: in acknowledge mode a received packet answers with a 20 ms burst
// R13: timing settings are two hex digits, stored to nonvolatile at once
// R14: preamble length is bit count times 620 microseconds
// R15: resend timeout is setting times 0.41 milliseconds
// R16: without acknowledge in time, resend up to the allowed attempts
// R17: a non-hex length character abandons the command, nothing sent
`timescale 1ns/1ns
`include "rmcs_defs.svh"
module rmcs_top #(
  parameter int IN_DEPTH = 4,
  parameter int PKT_DEPTH = 16,
  parameter int DELAY_UNIT_CYCLES = `RMCS_DELAY_UNIT_US * `RMCS_CLK_MHZ,
  parameter int SETTLE_BIT_CYCLES = `RMCS_SETTLE_BIT_US * `RMCS_CLK_MHZ,
  parameter int TAIL_UNIT_CYCLES = `RMCS_TAIL_UNIT_US * `RMCS_CLK_MHZ,
  parameter int TIMEOUT_UNIT_CYCLES = (`RMCS_TIMEOUT_UNIT_NS * `RMCS_CLK_MHZ) / 1000,
  parameter int ACK_UNIT_CYCLES = `RMCS_ACK_UNIT_US * `RMCS_CLK_MHZ
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic cmd_mode_i,
  input wire logic ack_mode_i,
  input wire logic host_rx_valid_i,
  input wire logic [7:0] host_rx_data_i,
  output logic host_rx_ready_o,
  output logic host_tx_valid_o,
  output logic [7:0] host_tx_data_o,
  input wire logic host_tx_ready_i,
  output logic radio_key_o,
  output logic settle_o,
  output logic ack_burst_o,
  output logic radio_tx_valid_o,
  output logic [7:0] radio_tx_data_o,
  input wire logic radio_tx_ready_i,
  input wire logic radio_rx_packet_i,
  input wire logic radio_rx_ack_i,
  input wire logic param_wr_i,
  input wire logic [2:0] param_sel_i,
  input wire logic [7:0] param_data_i,
  output logic nvm_wr_o,
  output logic [2:0] nvm_addr_o,
  output logic [7:0] nvm_data_o,
  output logic setup_mode_o
);
  import rmcs_pkg::*;

  rmcs_state_type state;
  rmcs_state_type next_state;
  logic [7:0] delay_val;
  logic [7:0] settle_bit_count;
  logic [7:0] tail_hold_time;
  logic [7:0] timeout_val;
  logic [7:0] tries_val;
  logic [3:0] cmd_len;
  logic [4:0] data_cnt;
  logic [7:0] attempt;
  logic is_cmd;
  logic [31:0] tick;
  logic [31:0] unit_len;
  logic [7:0] steps;
  logic [7:0] next_steps;
  logic [31:0] next_unit;
  logic in_valid;
  logic [7:0] in_data;
  logic pkt_ready;
  logic pkt_valid;
  logic [7:0] pkt_data;

  // hex digit decode of the length character
  wire logic is_digit = (in_data >= 8'h30) && (in_data <= 8'h39);
  wire logic is_upper = (in_data >= 8'h41) && (in_data <= 8'h46);
  wire logic is_lower = (in_data >= 8'h61) && (in_data <= 8'h66);
  wire logic is_hex = is_digit || is_upper || is_lower;
  wire logic [7:0] hex_adj = is_digit ? 8'h30 : (is_upper ? 8'h37 : 8'h57);
  wire logic [7:0] hex_diff = in_data - hex_adj;
  wire logic [3:0] hex_val = hex_diff[3:0];

  // fifo steering between host, packet buffer and radio
  wire logic st_idle_tp = (state == ST_IDLE) && !setup_mode_o;
  wire logic ack_pending = ack_mode_i && radio_rx_packet_i;
  wire logic fill_state = (st_idle_tp && !ack_pending) || (state == ST_DELAY) || (state == ST_CMD_DATA);
  wire logic xfer = ce_i && fill_state && in_valid && pkt_ready;
  wire logic drop_pop = ce_i && in_valid && (((state == ST_IDLE) && setup_mode_o && !ack_pending)
                                             || (state == ST_CMD_LEN));
  wire logic in_pop = xfer || drop_pop;
  wire logic radio_take = ce_i && (state == ST_SEND) && pkt_valid && (!radio_tx_valid_o || radio_tx_ready_i);
  wire logic send_done = (state == ST_SEND) && !pkt_valid && !radio_tx_valid_o;
  wire logic timer_done = (steps == 8'h00);
  // greater-or-equal so a one-cycle unit still wraps on every edge
  wire logic tick_wrap = (tick >= unit_len - 32'h1);
  wire logic timer_load = ce_i && (next_state != state);
  wire logic first_key = (next_state == ST_PREAMBLE) && ((state == ST_DELAY) || (state == ST_CMD_DATA));
  wire logic can_resend = attempt < tries_val;
  wire logic pkt_rewind = (state == ST_ACK_WAIT) && timer_done && !radio_rx_ack_i && can_resend;
  wire logic key_next = (next_state == ST_PREAMBLE) || (next_state == ST_SEND)
                        || (next_state == ST_HOLD) || (next_state == ST_ACK_BURST);

  // host bytes land here; a full fifo drops ready so 4800 baud streams stall, not overflow
  rmcs_fifo #(.WIDTH(8), .DEPTH(IN_DEPTH)) u_in_fifo (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .in_valid_i(host_rx_valid_i),
    .in_data_i(host_rx_data_i),
    .in_ready_o(host_rx_ready_o), // see R11
    .out_valid_o(in_valid),
    .out_data_o(in_data),
    .out_ready_i(in_pop),
    .mark_i(1'b0),
    .rewind_i(1'b0)
  );

  // packet buffer; mark at first key-up so a resend replays the same bytes
  rmcs_fifo #(.WIDTH(8), .DEPTH(PKT_DEPTH)) u_pkt_fifo (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .in_valid_i(xfer),
    .in_data_i(in_data),
    .in_ready_o(pkt_ready),
    .out_valid_o(pkt_valid),
    .out_data_o(pkt_data),
    .out_ready_i(radio_take),
    .mark_i(first_key),
    .rewind_i(pkt_rewind) // see R16
  );

  // sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (ack_pending) next_state = ST_ACK_BURST; // see R12
        else if (setup_mode_o && in_valid && (in_data == `RMCS_CMD_TX_BYTE)) next_state = ST_CMD_LEN; // see R1
        else if (!setup_mode_o && in_valid) next_state = ST_DELAY; // see R6
      end
      ST_CMD_LEN: begin
        if (in_valid && is_hex) next_state = ST_CMD_PROMPT; // see R1
        else if (in_valid) next_state = ST_IDLE; // see R17
      end
      ST_CMD_PROMPT: if (host_tx_ready_i) next_state = ST_CMD_DATA; // see R3
      ST_CMD_DATA: if (xfer && (data_cnt == {1'b0, cmd_len})) next_state = ST_PREAMBLE; // see R2
      ST_DELAY: if (timer_done) next_state = ST_PREAMBLE; // see R9
      ST_PREAMBLE: if (timer_done) next_state = ST_SEND; // see R8
      ST_SEND: if (send_done) next_state = ack_mode_i ? ST_ACK_WAIT : ST_HOLD;
      ST_ACK_WAIT: begin
        if (radio_rx_ack_i) next_state = ST_HOLD;
        else if (timer_done) next_state = can_resend ? ST_PREAMBLE : ST_HOLD; // see R16
      end
      ST_HOLD: if (timer_done) next_state = ST_IDLE; // see R10
      ST_ACK_BURST: if (timer_done) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // length and unit of the phase being entered
  always_comb begin
    next_steps = 8'h00;
    next_unit = 32'h1;
    case (next_state)
      ST_DELAY: begin
        next_steps = delay_val; // see R6
        next_unit = 32'(DELAY_UNIT_CYCLES);
      end
      ST_PREAMBLE: begin
        next_steps = settle_bit_count; // see R14
        next_unit = 32'(SETTLE_BIT_CYCLES);
      end
      ST_HOLD: begin
        next_steps = tail_hold_time; // see R10
        next_unit = 32'(TAIL_UNIT_CYCLES);
      end
      ST_ACK_WAIT: begin
        next_steps = timeout_val; // see R15
        next_unit = 32'(TIMEOUT_UNIT_CYCLES);
      end
      ST_ACK_BURST: begin
        next_steps = `RMCS_ACK_BURST_MS; // see R12
        next_unit = 32'(ACK_UNIT_CYCLES);
      end
      default: begin
        next_steps = 8'h00;
        next_unit = 32'h1;
      end
    endcase
  end

  // two-level timer keeps the counter at 32 bits for 255 long units
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tick <= 32'h0;
      steps <= 8'h00;
      unit_len <= 32'h1;
    end else if (timer_load) begin
      tick <= 32'h1; // load edge is the first cycle of the phase, so it lasts steps * unit exactly
      steps <= next_steps;
      unit_len <= next_unit;
    end else if (ce_i && !timer_done) begin
      tick <= tick_wrap ? 32'h0 : tick + 32'h1;
      if (tick_wrap) steps <= steps - 8'h01;
    end
  end

  // state, command bookkeeping and attempt count
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= ST_IDLE;
      cmd_len <= 4'h0;
      data_cnt <= 5'h00;
      is_cmd <= 1'b0;
      attempt <= 8'h00;
    end else if (ce_i) begin
      state <= next_state;
      if ((state == ST_CMD_LEN) && in_valid && is_hex) cmd_len <= hex_val; // see R2
      if (next_state == ST_CMD_PROMPT) data_cnt <= 5'h00;
      else if (xfer && (state == ST_CMD_DATA)) data_cnt <= data_cnt + 5'h01;
      if (next_state == ST_CMD_LEN) is_cmd <= 1'b1;
      else if ((state == ST_IDLE) && (next_state == ST_DELAY)) is_cmd <= 1'b0;
      if (first_key) attempt <= 8'h01;
      else if (pkt_rewind) attempt <= attempt + 8'h01; // see R16
    end
  end

  // registered radio and host strobes
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      radio_key_o <= 1'b0;
      settle_o <= 1'b0;
      ack_burst_o <= 1'b0;
      host_tx_valid_o <= 1'b0;
      host_tx_data_o <= 8'h00;
    end else if (ce_i) begin
      radio_key_o <= key_next; // see R4
      settle_o <= (next_state == ST_PREAMBLE); // see R8
      ack_burst_o <= (next_state == ST_ACK_BURST); // see R12
      host_tx_valid_o <= (next_state == ST_CMD_PROMPT); // see R3
      host_tx_data_o <= (next_state == ST_CMD_PROMPT) ? `RMCS_PROMPT_BYTE : 8'h00;
    end
  end

  // radio byte register; holds until the transceiver takes it
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      radio_tx_valid_o <= 1'b0;
      radio_tx_data_o <= 8'h00;
    end else if (ce_i) begin
      if (radio_take) begin
        radio_tx_valid_o <= 1'b1; // see R4
        radio_tx_data_o <= pkt_data;
      end else if (radio_tx_ready_i) begin
        radio_tx_valid_o <= 1'b0;
      end
    end
  end

  // mode follows the input only while idle; a command send lands back in setup
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      setup_mode_o <= 1'b0;
    end else if (ce_i) begin
      if ((state == ST_HOLD) && timer_done && is_cmd) setup_mode_o <= 1'b1; // see R5
      else if (state == ST_IDLE) setup_mode_o <= cmd_mode_i;
    end
  end

  // timing settings apply at once and are copied to nonvolatile storage
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      delay_val <= `RMCS_DEF_DELAY; // see R7
      settle_bit_count <= `RMCS_DEF_SETTLE; // see R7
      tail_hold_time <= `RMCS_DEF_TAIL;
      timeout_val <= `RMCS_DEF_TIMEOUT;
      tries_val <= `RMCS_DEF_TRIES;
      nvm_wr_o <= 1'b0;
      nvm_addr_o <= 3'h0;
      nvm_data_o <= 8'h00;
    end else if (ce_i) begin
      nvm_wr_o <= param_wr_i; // see R13
      if (param_wr_i) begin
        nvm_addr_o <= param_sel_i;
        nvm_data_o <= param_data_i;
        if (param_sel_i == `RMCS_SEL_DELAY) delay_val <= param_data_i; // see R13
        if (param_sel_i == `RMCS_SEL_SETTLE) settle_bit_count <= param_data_i;
        if (param_sel_i == `RMCS_SEL_TAIL) tail_hold_time <= param_data_i;
        if (param_sel_i == `RMCS_SEL_TIMEOUT) timeout_val <= param_data_i;
        if (param_sel_i == `RMCS_SEL_TRIES) tries_val <= param_data_i;
      end
    end
  end

  // checks on the sequencer
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  chk_len_prompt: assert property ((state == ST_CMD_LEN) && ce_i && in_valid && is_hex // see R3
    |=> host_tx_valid_o && (host_tx_data_o == 8'h3A)) else $error("no colon after length");
  chk_bad_len: assert property ((state == ST_CMD_LEN) && ce_i && in_valid && !is_hex // see R17
    |=> (state == ST_IDLE) && !radio_key_o) else $error("bad length not abandoned");
  chk_len_count: assert property ((state == ST_CMD_DATA) && xfer && (data_cnt == {1'b0, cmd_len}) // see R2
    |=> (state == ST_PREAMBLE) && radio_key_o) else $error("packet length wrong");
  chk_key_settle: assert property ((state == ST_PREAMBLE) |-> radio_key_o && settle_o && !radio_tx_valid_o) // see R8
    else $error("preamble without key");
  chk_closed_packet: assert property ((state == ST_PREAMBLE) || (state == ST_SEND) |-> !xfer) // see R9
    else $error("packet grew after formatting");
  chk_cmd_setup: assert property ((state == ST_HOLD) && ce_i && timer_done && is_cmd // see R5
    |=> setup_mode_o && (state == ST_IDLE)) else $error("left setup after command send");
  chk_hold_block: assert property ((state == ST_HOLD) && !timer_done // see R10
    |=> (state == ST_HOLD) && radio_key_o) else $error("hold-off cut short");
  chk_param_store: assert property (param_wr_i && ce_i // see R13
    |=> nvm_wr_o && (nvm_data_o == $past(param_data_i))) else $error("setting not stored");
  chk_first_delay: assert property (st_idle_tp && ce_i && in_valid && !ack_pending // see R6
    |=> (state == ST_DELAY) && (steps == delay_val)) else $error("start delay not begun");
  chk_resend: assert property (pkt_rewind && ce_i // see R16
    |=> (state == ST_PREAMBLE) && (attempt == $past(attempt) + 8'h01)) else $error("no resend");
  chk_ack_burst: assert property ((state == ST_ACK_BURST) |-> radio_key_o && ack_burst_o) // see R12
    else $error("ack burst without key");
  chk_defaults: assert property ($rose(reset_n_i) |-> (delay_val == 8'h05) && (settle_bit_count == 8'h11)) // see R7
    else $error("wrong power-on timing");

  cov_cmd_send: cover property ((state == ST_SEND) && is_cmd ##1 (state == ST_HOLD));
  cov_resend: cover property (pkt_rewind);
  cov_ack_burst: cover property ((state == ST_IDLE) ##1 (state == ST_ACK_BURST));
  cov_stream: cover property ((state == ST_DELAY) && !host_rx_ready_o);
endmodule : rmcs_top

// *** verification/rmcs_partner_model.sv ***
// behavioural host terminal and radio transceiver facing the sequencer
`timescale 1ns/1ns
module rmcs_partner_model (
  input wire logic clock_i,
  input wire logic radio_key_i,
  input wire logic settle_i,
  input wire logic radio_valid_i,
  input wire logic [7:0] radio_data_i,
  input wire logic host_valid_i,
  input wire logic [7:0] host_data_i,
  output logic radio_ready_o,
  output logic host_ready_o
);
  logic [7:0] rx_q[$];
  logic [7:0] last_prompt;
  logic settle_prev;
  logic key_prev;
  int seed = 32'h1F2E3D4C;
  int pkt_count, prompt_count, settle_cycles, hold_cycles, gap, last_gap, early;

  // quiet start: nothing taken before the first falling edge
  initial begin
    radio_ready_o = 1'b0;
    host_ready_o = 1'b0;
    last_prompt = 8'h00;
    settle_prev = 1'b0;
    key_prev = 1'b0;
    {pkt_count, prompt_count, settle_cycles, hold_cycles, gap, last_gap, early} = '0;
  end

  // random stalls, as a slow transceiver or a busy terminal would give
  always @(negedge clock_i) begin
    radio_ready_o <= ($random(seed) % 4) != 0;
    host_ready_o <= ($random(seed) % 2) != 0;
  end

  // capture packet bytes, preamble length, hold-off and key-off gaps
  always @(posedge clock_i) begin
    settle_prev <= settle_i;
    key_prev <= radio_key_i;
    if (radio_valid_i && radio_ready_o) rx_q.push_back(radio_data_i);
    if (radio_valid_i && settle_i) early++;
    if (settle_i && !settle_prev) begin
      pkt_count++;
      settle_cycles = 1;
    end else if (settle_i) settle_cycles++;
    if (radio_valid_i) hold_cycles = 0;
    else if (radio_key_i && !settle_i) hold_cycles++;
    if (radio_key_i && !key_prev) begin
      last_gap = gap;
      gap = 0;
    end else if (!radio_key_i) gap++;
    if (host_valid_i && host_ready_o) begin
      prompt_count++;
      last_prompt = host_data_i;
    end
  end
endmodule : rmcs_partner_model

// *** verification/tb_top.sv ***
// self-checking bench of the modem transmit sequencer
`timescale 1ns/1ns
`include "rmcs_defs.svh"
module tb_top;
  import rmcs_pkg::*;
  logic clock_i, reset_n_i, ce_i, cmd_mode_i, ack_mode_i, host_rx_valid_i, host_rx_ready_o, host_tx_valid_o;
  logic host_tx_ready_i, radio_key_o, settle_o, ack_burst_o, radio_tx_valid_o, radio_tx_ready_i;
  logic radio_rx_packet_i, radio_rx_ack_i, param_wr_i, nvm_wr_o, setup_mode_o, ce_rand;
  logic [7:0] host_rx_data_i, host_tx_data_o, radio_tx_data_o, param_data_i, nvm_data_o;
  logic [2:0] param_sel_i, nvm_addr_o;
  logic [7:0] exp_q[$];
  int failures, cmp_count, k0, r0, n;
  int seed = 32'h7CCF9A5E;

  // short time units keep every phase a handful of cycles
  rmcs_top #(.IN_DEPTH(4), .PKT_DEPTH(16), .DELAY_UNIT_CYCLES(8), .SETTLE_BIT_CYCLES(4),
    .TAIL_UNIT_CYCLES(8), .TIMEOUT_UNIT_CYCLES(8), .ACK_UNIT_CYCLES(4)) dut (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .cmd_mode_i(cmd_mode_i),
    .ack_mode_i(ack_mode_i), .host_rx_valid_i(host_rx_valid_i), .host_rx_data_i(host_rx_data_i),
    .host_rx_ready_o(host_rx_ready_o), .host_tx_valid_o(host_tx_valid_o), .host_tx_data_o(host_tx_data_o),
    .host_tx_ready_i(host_tx_ready_i), .radio_key_o(radio_key_o), .settle_o(settle_o),
    .ack_burst_o(ack_burst_o), .radio_tx_valid_o(radio_tx_valid_o), .radio_tx_data_o(radio_tx_data_o),
    .radio_tx_ready_i(radio_tx_ready_i), .radio_rx_packet_i(radio_rx_packet_i),
    .radio_rx_ack_i(radio_rx_ack_i), .param_wr_i(param_wr_i), .param_sel_i(param_sel_i),
    .param_data_i(param_data_i), .nvm_wr_o(nvm_wr_o), .nvm_addr_o(nvm_addr_o),
    .nvm_data_o(nvm_data_o), .setup_mode_o(setup_mode_o));

  // far side: terminal taking prompts, transceiver taking packet bytes
  rmcs_partner_model part (
    .clock_i(clock_i), .radio_key_i(radio_key_o), .settle_i(settle_o), .radio_valid_i(radio_tx_valid_o),
    .radio_data_i(radio_tx_data_o), .host_valid_i(host_tx_valid_o), .host_data_i(host_tx_data_o),
    .radio_ready_o(radio_tx_ready_i), .host_ready_o(host_tx_ready_i));

  function automatic logic [7:0] hex_char(input logic [3:0] c, input logic lower);
    hex_char = (c < 4'hA) ? 8'h30 + c : (lower ? 8'h57 : 8'h37) + c;
  endfunction : hex_char

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task stop_test;
    if (failures == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  // valid is held across back-to-back bytes; only send_end drops it
  task send_byte(input logic [7:0] b);
    int w;
    w = 0;
    @(negedge clock_i);
    host_rx_valid_i = 1'b1;
    host_rx_data_i = b;
    // received-packet strobe is noise outside acknowledge mode
    if (!ack_mode_i) radio_rx_packet_i = 1'($random(seed));
    if (ce_rand) ce_i = 1'($random(seed));
    // a byte only lands on an edge with ready and clock enable both high
    while ((host_rx_ready_o !== 1'b1 || ce_i !== 1'b1) && w < 2000) begin
      @(negedge clock_i);
      if (ce_rand) ce_i = 1'($random(seed));
      w++;
    end
    @(posedge clock_i);
  endtask : send_byte

  task send_end;
    @(negedge clock_i);
    host_rx_valid_i = 1'b0;
    radio_rx_packet_i = 1'b0;
    ce_i = 1'b1;
    ce_rand = 1'b0;
  endtask : send_end

  task wait_key(input logic v);
    int w;
    w = 0;
    while (radio_key_o !== v && w < 2000) begin
      @(negedge clock_i);
      w++;
    end
  endtask : wait_key

  // idle is taken as 100 cycles with the transmitter off
  task wait_quiet;
    int q, w;
    q = 0;
    w = 0;
    while (q < 100 && w < 5000) begin
      @(negedge clock_i);
      q = (radio_key_o === 1'b0) ? q + 1 : 0;
      w++;
    end
  endtask : wait_quiet

  task write_param(input logic [2:0] sel, input logic [7:0] d);
    @(negedge clock_i);
    param_wr_i = 1'b1;
    param_sel_i = sel;
    param_data_i = d;
    @(negedge clock_i);
    param_wr_i = 1'b0;
    chk({nvm_wr_o, nvm_addr_o, nvm_data_o}, {1'b1, sel, d});
    @(negedge clock_i);
    chk(nvm_wr_o, 1'b0);
  endtask : write_param

  // transparent burst, then four late bytes pushed during the preamble
  task stream_send(input int dly, input int pre, input int tail);
    time t0;
    k0 = part.pkt_count;
    r0 = part.rx_q.size();
    exp_q = {};
    n = 0;
    t0 = 0;
    for (int i = 0; i < 7; i++) exp_q.push_back(8'($random(seed)));
    for (int i = 0; i < 3; i++) begin
      send_byte(exp_q[i]);
      if (i == 0) t0 = $time;
    end
    send_end;
    while (settle_o !== 1'b1 && n < 4000) begin
      @(negedge clock_i);
      n++;
    end
    chk(($time - t0) >= dly * 4, 1'b1);
    for (int i = 3; i < 7; i++) send_byte(exp_q[i]);
    send_end;
    @(negedge clock_i);
    chk(host_rx_ready_o, 1'b0);
    chk(part.rx_q.size(), r0);
    wait_quiet;
    chk(part.pkt_count, k0 + 2);
    for (int i = 0; i < 7; i++) chk(part.rx_q[r0 + i], exp_q[i]);
    chk(part.rx_q.size(), r0 + 7);
    chk(part.settle_cycles, pre);
    chk(part.hold_cycles >= tail && part.hold_cycles <= tail + 2, 1'b1);
    chk(host_rx_ready_o, 1'b1);
  endtask : stream_send

  task cmd_send(input logic [3:0] code, input logic bad);
    int p0;
    k0 = part.pkt_count;
    p0 = part.prompt_count;
    r0 = part.rx_q.size();
    exp_q = {};
    ce_rand = bad; // the rejected command also runs with the clock enable stuttering
    send_byte(`RMCS_CMD_TX_BYTE);
    send_byte(bad ? 8'h47 : hex_char(code, code[0]));
    if (!bad) for (int i = 0; i <= code; i++) begin
      exp_q.push_back(8'($random(seed)));
      send_byte(exp_q[i]);
    end
    send_end;
    wait_quiet;
    chk(part.pkt_count, k0 + (bad ? 0 : 1));
    chk(part.prompt_count, p0 + (bad ? 0 : 1));
    chk(part.last_prompt, `RMCS_PROMPT_BYTE);
    chk(part.rx_q.size(), r0 + exp_q.size());
    for (int i = 0; i < exp_q.size(); i++) chk(part.rx_q[r0 + i], exp_q[i]);
    chk(setup_mode_o, 1'b1);
    chk(part.settle_cycles, 12);
  endtask : cmd_send

  // free-running 250 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  // watchdog well beyond the expected run
  initial begin
    #200000;
    failures++;
    stop_test;
  end

  // main sequence
  initial begin
    {reset_n_i, cmd_mode_i, ack_mode_i, host_rx_valid_i, radio_rx_packet_i, radio_rx_ack_i, param_wr_i} = '0;
    ce_i = 1'b1;
    ce_rand = 1'b0;
    host_rx_data_i = 8'h00;
    param_sel_i = 3'h0;
    param_data_i = 8'h00;
    repeat (3) @(posedge clock_i);
    chk({host_rx_ready_o, radio_key_o, host_tx_valid_o, nvm_wr_o, setup_mode_o}, 5'h10);
    @(negedge clock_i);
    reset_n_i = 1'b1;
    stream_send(40, 68, 40);
    for (int s = 0; s < 5; s++) write_param(3'(s), 8'($random(seed)));
    write_param(`RMCS_SEL_DELAY, 8'h02);
    write_param(`RMCS_SEL_SETTLE, 8'h03);
    write_param(`RMCS_SEL_TAIL, 8'h02);
    write_param(`RMCS_SEL_TIMEOUT, 8'h04);
    write_param(`RMCS_SEL_TRIES, 8'h03);
    stream_send(16, 12, 16);
    cmd_mode_i = 1'b1;
    repeat (2) @(negedge clock_i);
    for (int c = 0; c < 16; c++) cmd_send(4'(c), 1'b0);
    cmd_send(4'h0, 1'b1);
    cmd_mode_i = 1'b0;
    ack_mode_i = 1'b1;
    k0 = part.pkt_count;
    r0 = part.rx_q.size();
    send_byte(8'h5A);
    send_end;
    wait_quiet;
    chk(part.pkt_count, k0 + 3);
    chk(part.rx_q.size(), r0 + 3);
    chk(part.last_gap >= 32 && part.last_gap <= 34, 1'b1);
    k0 = part.pkt_count;
    send_byte(8'hA5);
    send_end;
    wait_key(1'b1);
    wait_key(1'b0);
    radio_rx_ack_i = 1'b1;
    @(negedge clock_i);
    radio_rx_ack_i = 1'b0;
    wait_quiet;
    chk(part.pkt_count, k0 + 1);
    radio_rx_packet_i = 1'b1;
    @(negedge clock_i);
    radio_rx_packet_i = 1'b0;
    wait_key(1'b1);
    n = 0;
    while (ack_burst_o === 1'b1 && n < 500) begin
      @(negedge clock_i);
      n++;
    end
    chk(n, 80);
    chk(part.early, 0);
    stop_test;
  end
endmodule : tb_top
